// File: rtl/aab_map.vh
// Purpose: Constants for the accumulator ALU and bit-operation datapath
// Assumes: Included by bare name from rtl files
// Notes: Operation codes are local to this block's decoder interface
`ifndef AAB_MAP_VH
`define AAB_MAP_VH

// Operation select codes
`define AAB_OP_NOP 3'h0
`define AAB_OP_ADD_IMM 3'h1
`define AAB_OP_ADD_REG 3'h2
`define AAB_OP_AND_IMM 3'h3
`define AAB_OP_AND_REG 3'h4
`define AAB_OP_CLR_BIT 3'h5
`define AAB_OP_SET_BIT 3'h6
`define AAB_OP_SKIP_LOW 3'h7

// Destination select values
`define AAB_DEST_ACC 1'h0
`define AAB_DEST_REG 1'h1
`define AAB_DEST_DEFAULT 1'h1

// Status field positions
`define AAB_ST_CARRY 0
`define AAB_ST_NIBBLE 1
`define AAB_ST_ZERO 2

// Reset values
`define AAB_ACC_RST 8'h00
`define AAB_STATUS_RST 3'h0

// Timing: oscillator periods per instruction cycle
`define AAB_OSC_PER_CYCLE 4
`define AAB_PHASE_LAST 2'h3

// Operand limits
`define AAB_FILE_ADDR_MAX 7'h7f
`define AAB_BIT_POS_MAX 3'h7

`endif

// File: rtl/aab_alu.v
// Purpose: Combinational add and AND unit with flag generation
// Assumes: 8-bit operands
// Notes: Zero flag from the 8-bit result only
`timescale 1ns/100ps
`include "aab_map.vh"

module aab_alu (
  // Operands
  input wire [7:0] i_a,
  input wire [7:0] i_b,
  input wire i_is_add,
  // Result and flags
  output reg [7:0] o_res,
  output reg o_carry,
  output reg o_nibble_overflow_flag,
  output reg o_zero
);

  reg [8:0] sum;
  reg [4:0] low_sum;

  always @* begin
    sum = {1'b0, i_a} + {1'b0, i_b};
    low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    if (i_is_add) begin
      o_res = sum[7:0];
    end else begin
      o_res = i_a & i_b;
    end
    o_carry = sum[8];
    o_nibble_overflow_flag = low_sum[4];
    o_zero = (o_res == 8'h00);
  end

endmodule

// File: rtl/aab_core.v
// Purpose: Execution datapath for accumulator add/AND and bit operations
// Assumes: Decoder holds the instruction steady for a whole cycle
// Notes: Four oscillator phases form one instruction cycle
//
// Operation
// - Destination bit 0 writes acc, 1 register
// - Bit ops pick bit 0-7, address 0-127
// - Add immediate sums acc and literal into acc
// - Add register result goes to chosen destination
// - AND immediate result goes to acc
// - AND register result goes to chosen destination
// - Bit clear zeroes bit, flags unchanged
// - Bit set ones bit, flags unchanged
// - Skip when tested bit low, two cycles
// - Instruction cycle spans four oscillator periods
// - File register is read, modified, written back by bit set/clear and register-dest ops
`timescale 1ns/100ps
`include "aab_map.vh"

module aab_core (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_ce,
  // Instruction from decoder
  input wire i_instr_valid,
  input wire [2:0] i_op,
  input wire [6:0] i_file_addr,
  input wire [2:0] i_bit_pos,
  input wire i_dest,
  input wire [7:0] i_literal,
  // Register file read
  input wire [7:0] i_reg_rdata,
  // Register file access
  output reg [6:0] o_reg_addr,
  output reg o_reg_rd,
  output reg o_reg_wr,
  output reg [7:0] o_reg_wdata,
  // State
  output reg [7:0] o_acc,
  output reg o_carry,
  output reg o_nibble_overflow_flag,
  output reg o_zero,
  output reg o_cycle_end,
  output reg o_instr_ready,
  output reg o_skip_active
);

  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_SKIP = 2'h2;

  reg [1:0] state;
  reg [1:0] next_state;
  reg [1:0] phase;
  reg [2:0] op;
  reg [2:0] bpos;
  reg dest;
  reg [7:0] lit;
  reg [7:0] operand;
  wire [7:0] bit_mask;
  wire [7:0] alu_b;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire is_reg_op;
  wire is_add;
  wire bit_low;
  wire phase_end;

  assign is_add = (op == `AAB_OP_ADD_IMM) || (op == `AAB_OP_ADD_REG);
  assign is_reg_op = (op == `AAB_OP_ADD_REG) || (op == `AAB_OP_AND_REG) ||
                     (op == `AAB_OP_CLR_BIT) || (op == `AAB_OP_SET_BIT) ||
                     (op == `AAB_OP_SKIP_LOW);
  assign phase_end = (phase == `AAB_PHASE_LAST);
  // Tested bit is valid once the operand is captured
  assign bit_low = ~operand[bpos];
  // Immediate ops take the literal, others the file value
  assign alu_b = (op == `AAB_OP_ADD_IMM || op == `AAB_OP_AND_IMM) ?
                 lit : operand;

  // One-hot mask for the selected bit
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_mask
      assign bit_mask[g] = ({29'h0, bpos} == g);
    end
  endgenerate

  aab_alu u_alu (
    .i_a(o_acc),
    .i_b(alu_b),
    .i_is_add(is_add),
    .o_res(alu_res),
    .o_carry(alu_c),
    .o_nibble_overflow_flag(alu_dc),
    .o_zero(alu_z)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (i_instr_valid) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (phase_end) begin
          if (op == `AAB_OP_SKIP_LOW && bit_low) begin
            next_state = ST_SKIP;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_SKIP: begin
        // Discarded slot; the decoder drops its word
        if (phase_end) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      phase <= 2'h0;
      op <= `AAB_OP_NOP;
      bpos <= 3'h0;
      dest <= `AAB_DEST_DEFAULT;
      lit <= 8'h00;
      operand <= 8'h00;
      o_reg_addr <= 7'h00;
      o_reg_rd <= 1'b0;
      o_reg_wr <= 1'b0;
      o_reg_wdata <= 8'h00;
      o_acc <= `AAB_ACC_RST;
      o_carry <= 1'b0;
      o_nibble_overflow_flag <= 1'b0;
      o_zero <= 1'b0;
      o_cycle_end <= 1'b0;
      o_instr_ready <= 1'b0;
      o_skip_active <= 1'b0;
    end else if (i_ce) begin
      // Clock enable low freezes every register
      state <= next_state;
      o_reg_rd <= 1'b0;
      o_reg_wr <= 1'b0;
      o_cycle_end <= 1'b0;
      // Ready tracks the idle state of the next edge
      o_instr_ready <= (next_state == ST_IDLE);
      o_skip_active <= (next_state == ST_SKIP);
      // Fields are latched only when idle
      if (state == ST_IDLE) begin
        phase <= 2'h0;
        if (i_instr_valid) begin
          op <= i_op;
          bpos <= i_bit_pos;
          dest <= i_dest;
          lit <= i_literal;
          o_reg_addr <= i_file_addr;
        end
      end else begin
        phase <= phase + 2'h1;
        if (phase_end) begin
          o_cycle_end <= 1'b1;
        end
      end
      if (state == ST_EXEC) begin
        // Phase 0 reads, phase 1 captures, phase 3 writes back
        if (phase == 2'h0 && is_reg_op) begin
          o_reg_rd <= 1'b1;
        end
        if (phase == 2'h1) begin
          operand <= i_reg_rdata;
        end
        if (phase_end) begin
          case (op)
            `AAB_OP_ADD_IMM, `AAB_OP_AND_IMM: begin
              o_acc <= alu_res;
            end
            `AAB_OP_ADD_REG, `AAB_OP_AND_REG: begin
              if (dest == `AAB_DEST_ACC) begin
                o_acc <= alu_res;
              end else begin
                o_reg_wr <= 1'b1;
                o_reg_wdata <= alu_res;
              end
            end
            `AAB_OP_CLR_BIT: begin
              o_reg_wr <= 1'b1;
              o_reg_wdata <= operand & ~bit_mask;
            end
            `AAB_OP_SET_BIT: begin
              o_reg_wr <= 1'b1;
              o_reg_wdata <= operand | bit_mask;
            end
            default: begin
              o_reg_wr <= 1'b0;
            end
          endcase
          // Bit ops and skip leave every flag alone
          if (is_add) begin
            o_carry <= alu_c;
            o_nibble_overflow_flag <= alu_dc;
            o_zero <= alu_z;
          end else if (op == `AAB_OP_AND_IMM || op == `AAB_OP_AND_REG) begin
            o_zero <= alu_z;
          end
        end
      end
    end
  end

endmodule

// File: testbench/aab_props.sv
// Purpose: Port timing checks for aab_core
// Assumes: i_ce low only while idle
// Notes: Bound to aab_core
`timescale 1ns/100ps
`include "aab_map.vh"
module aab_props (
  // Clock, reset and decoder side
  input wire i_sys_clk, i_rstn, i_ce, i_instr_valid, i_dest,
  input wire [2:0] i_op,
  // Register file side and state
  input wire [6:0] o_reg_addr,
  input wire [7:0] o_acc,
  input wire o_reg_rd, o_reg_wr, o_carry, o_nibble_overflow_flag, o_zero,
  input wire o_cycle_end, o_instr_ready, o_skip_active
);
  wire take = i_ce && o_instr_ready && i_instr_valid;
  wire imm_op = i_op == `AAB_OP_ADD_IMM || i_op == `AAB_OP_AND_IMM;
  wire and_op = i_op == `AAB_OP_AND_IMM || i_op == `AAB_OP_AND_REG;
  wire bit_op = i_op >= `AAB_OP_CLR_BIT;
  wire rr_op = i_op == `AAB_OP_ADD_REG || i_op == `AAB_OP_AND_REG;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  a_read_after_take: assert property (
    take && (rr_op || bit_op) |=> !o_reg_rd ##1 o_reg_rd)
    else $error("read missing");
  a_write_after_read: assert property (
    o_reg_wr |-> $past(o_reg_rd, 3)) else $error("write unread");
  a_imm_no_bus: assert property (
    take && imm_op |=> (!o_reg_rd && !o_reg_wr)[*5])
    else $error("imm bus use");
  a_cycle_four: assert property (
    take |=> (!o_cycle_end && !o_instr_ready)[*4] ##1 o_cycle_end)
    else $error("cycle length");
  a_skip_length: assert property (
    $rose(o_skip_active) |-> (o_skip_active && !o_instr_ready)[*4]
    ##1 (o_cycle_end && !o_skip_active)) else $error("skip length");
  a_bit_keeps_state: assert property (
    take && bit_op |=>
    $stable({o_acc, o_carry, o_nibble_overflow_flag, o_zero})[*8])
    else $error("bit op state");
  a_dest_keeps_acc: assert property (
    take && rr_op && i_dest |=> $stable(o_acc)[*6])
    else $error("acc touched");
  a_addr_held: assert property (
    o_reg_rd |=> $stable(o_reg_addr)[*3]) else $error("addr moved");
  a_and_keeps_carry: assert property (
    take && and_op |=> $stable({o_carry, o_nibble_overflow_flag})[*6])
    else $error("and carry");
endmodule
bind aab_core aab_props u_props (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_ce(i_ce), .i_instr_valid(i_instr_valid), .i_dest(i_dest), .i_op(i_op),
  .o_reg_addr(o_reg_addr), .o_acc(o_acc), .o_reg_rd(o_reg_rd),
  .o_reg_wr(o_reg_wr), .o_carry(o_carry),
  .o_nibble_overflow_flag(o_nibble_overflow_flag), .o_zero(o_zero),
  .o_cycle_end(o_cycle_end), .o_instr_ready(o_instr_ready),
  .o_skip_active(o_skip_active));

// File: testbench/aab_regfile.sv
// Purpose: File register model
// Assumes: Read data sampled while read strobe high
// Notes: Off-read data is inverted
`timescale 1ns/100ps
module aab_regfile (
  input wire i_sys_clk, i_rd, i_wr,
  input wire [6:0] i_addr,
  input wire [7:0] i_wdata,
  output wire [7:0] o_rdata
);
  logic [7:0] mem [0:127];
  logic rd_d = 0;
  always @(posedge i_sys_clk) begin
    rd_d <= i_rd;
    if (i_wr) mem[i_addr] <= i_wdata;
  end
  assign o_rdata = (i_rd | rd_d) ? mem[i_addr] : ~mem[i_addr];
endmodule

// File: testbench/aab_core_test.sv
// Purpose: Self-checking bench for aab_core
// Assumes: i_ce low only while idle
// Notes: Inputs change on falling edge
`timescale 1ns/100ps
`include "aab_map.vh"
module aab_core_test;
  logic i_sys_clk = 0, i_rstn = 0, i_ce = 1, i_instr_valid = 0, i_dest = 0;
  logic [2:0] i_op = 0, i_bit_pos = 0;
  logic [6:0] i_file_addr = 0, o_reg_addr;
  logic [7:0] i_literal = 0, i_reg_rdata, o_reg_wdata, o_acc;
  logic o_reg_rd, o_reg_wr, o_carry, o_nibble_overflow_flag, o_zero;
  logic o_cycle_end, o_instr_ready, o_skip_active, skp;
  int err_total = 0, samples_checked = 0, n, ticks = 0;
  wire [2:0] flg = {o_carry, o_nibble_overflow_flag, o_zero};
  aab_core u_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_instr_valid(i_instr_valid), .i_op(i_op), .i_file_addr(i_file_addr),
    .i_bit_pos(i_bit_pos), .i_dest(i_dest), .i_literal(i_literal),
    .i_reg_rdata(i_reg_rdata), .o_reg_addr(o_reg_addr), .o_reg_rd(o_reg_rd),
    .o_reg_wr(o_reg_wr), .o_reg_wdata(o_reg_wdata), .o_acc(o_acc),
    .o_carry(o_carry), .o_nibble_overflow_flag(o_nibble_overflow_flag),
    .o_zero(o_zero), .o_cycle_end(o_cycle_end),
    .o_instr_ready(o_instr_ready), .o_skip_active(o_skip_active));
  aab_regfile u_rf (.i_sys_clk(i_sys_clk), .i_rd(o_reg_rd), .i_wr(o_reg_wr),
    .i_addr(o_reg_addr), .i_wdata(o_reg_wdata), .o_rdata(i_reg_rdata));
  always #25 i_sys_clk = ~i_sys_clk;
  task stop_test;
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_sys_clk) if (++ticks > 3000) begin
    err_total++;
    stop_test;
  end
  task chk(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task run(input [2:0] op, input [6:0] a, input [2:0] b, input d,
    input [7:0] k);
    while (o_instr_ready !== 1'b1) @(negedge i_sys_clk);
    {i_op, i_file_addr, i_bit_pos, i_dest, i_literal} = {op, a, b, d, k};
    i_instr_valid = 1;
    @(negedge i_sys_clk);
    i_instr_valid = 0;
    n = 0;
    skp = 0;
    while (o_instr_ready !== 1'b1) begin
      skp |= o_skip_active;
      @(negedge i_sys_clk);
      n++;
    end
  endtask
  task t_imm;
    run(`AAB_OP_ADD_IMM, 0, 0, 0, 8'h8f);
    chk("cycles", 8'h04, n);
    run(`AAB_OP_ADD_IMM, 0, 0, 0, 8'h71);
    chk("flags", 8'h07, flg);
    run(`AAB_OP_ADD_IMM, 0, 0, 0, 8'hf0);
    run(`AAB_OP_ADD_IMM, 0, 0, 0, 8'h20);
    chk("acc", 8'h10, o_acc);
    run(`AAB_OP_AND_IMM, 0, 0, 0, 8'h0f);
    chk("acc", 8'h00, o_acc);
    chk("flags", 8'h05, flg);
  endtask
  task t_reg;
    run(`AAB_OP_ADD_REG, 7'h05, 0, `AAB_DEST_ACC, 0);
    chk("acc", 8'h0c, o_acc);
    run(`AAB_OP_AND_REG, 7'h7f, 0, `AAB_DEST_REG, 0);
    run(`AAB_OP_ADD_REG, 7'h05, 0, `AAB_DEST_REG, 0);
    @(negedge i_sys_clk);
    chk("reg", 8'h08, u_rf.mem[127]);
    chk("reg", 8'h18, u_rf.mem[5]);
    chk("flags", 8'h02, flg);
    run(`AAB_OP_AND_REG, 7'h05, 0, `AAB_DEST_ACC, 0);
    chk("acc", 8'h08, o_acc);
  endtask
  task t_bits;
    for (int b = 0; b < 8; b++) run(`AAB_OP_SET_BIT, 7'h01, b, 0, 0);
    @(negedge i_sys_clk);
    chk("reg", 8'hff, u_rf.mem[1]);
    for (int b = 0; b < 8; b += 2) run(`AAB_OP_CLR_BIT, 7'h01, b, 0, 0);
    @(negedge i_sys_clk);
    chk("reg", 8'haa, u_rf.mem[1]);
  endtask
  task t_skip;
    run(`AAB_OP_SKIP_LOW, 7'h01, 3'h0, 0, 0);
    chk("skip", 8'h01, skp);
    chk("cycles", 8'h08, n);
    run(`AAB_OP_SKIP_LOW, 7'h01, 3'h7, 0, 0);
    chk("skip", 8'h00, skp);
  endtask
  task t_hold;
    {i_op, i_literal} = {`AAB_OP_ADD_IMM, 8'h01};
    i_ce = 0;
    i_instr_valid = 1;
    repeat (6) @(negedge i_sys_clk);
    chk("acc", 8'h08, o_acc);
    i_ce = 1;
    @(negedge i_sys_clk);
    i_instr_valid = 0;
    while (o_instr_ready !== 1'b1) @(negedge i_sys_clk);
    chk("acc", 8'h09, o_acc);
    chk("flags", 8'h00, flg);
  endtask
  initial begin
    u_rf.mem[1] = 8'h00;
    u_rf.mem[5] = 8'h0c;
    u_rf.mem[127] = 8'h0a;
    repeat (5) @(negedge i_sys_clk);
    i_rstn = 1;
    t_imm;
    t_reg;
    t_bits;
    t_skip;
    t_hold;
    stop_test;
  end
endmodule
